/* File: rtl/cfg_mgmt_consts.svh */
/*
 * Constants of the configuration management port: address fields,
 * register space size, read-only masks and reset values.
 * Assumes inclusion by bare name from every file of the port.
 */
`ifndef CFG_MGMT_CONSTS_SVH
`define CFG_MGMT_CONSTS_SVH

// ------------------------------------------------------------
// address layout (Dword address)
// ------------------------------------------------------------
`define MGMT_ADDR_W        19
`define MGMT_SPACE_BIT     18
`define MGMT_FUNC_HI       17
`define MGMT_FUNC_LO       10
`define MGMT_REG_HI        9
`define MGMT_REG_LO        0
`define MGMT_FUNC_W        8
`define MGMT_REG_W         10

// ------------------------------------------------------------
// data path
// ------------------------------------------------------------
`define MGMT_DATA_W        32
`define MGMT_BE_W          4
`define MGMT_BYTE_W        8

// ------------------------------------------------------------
// implemented register space
// ------------------------------------------------------------
`define MGMT_NUM_FUNC      2
`define MGMT_NUM_REGS      64
`define MGMT_IDX_W         6
`define MGMT_HDR_REGS      10'h010

// ------------------------------------------------------------
// header registers with read-only content
// ------------------------------------------------------------
`define MGMT_REG_IDENT     10'h000
`define MGMT_REG_CLASS     10'h002
`define MGMT_REG_BUSNUM    10'h006
`define MGMT_MASK_ALL_RO   32'hFFFFFFFF
`define MGMT_MASK_BUS_RO   32'hFF000000
`define MGMT_MASK_NONE     32'h00000000

// ------------------------------------------------------------
// reset values (identity value arbitrary)
// ------------------------------------------------------------
`define MGMT_RST_IDENT     32'h5A5AA5A5
`define MGMT_RST_CLASS     32'h06040000
`define MGMT_RST_ZERO      32'h00000000

`endif

/* File: rtl/cfg_mgmt_pkg.sv */
/*
 * Types shared by both ends of the configuration management port.
 * Assumes cfg_mgmt_consts.svh is available on the include path.
 */
package cfg_mgmt_pkg;

	// ------------------------------------------------------------
	// device end sequencing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_HOLD = 2'b01
	} dev_state_e;

	// ------------------------------------------------------------
	// requester end sequencing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		REQ_IDLE = 2'b00,
		REQ_WAIT = 2'b01,
		REQ_DROP = 2'b10
	} req_state_e;

endpackage

/* File: rtl/cfg_mgmt_if.sv */
/*
 * Wires between the configuration manager and the configuration space.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
`include "cfg_mgmt_consts.svh"

interface cfg_mgmt_if;
	logic [`MGMT_ADDR_W-1:0] mgmt_addr;
	logic                    mgmt_write;
	logic [`MGMT_DATA_W-1:0] mgmt_write_data;
	logic [`MGMT_BE_W-1:0]   mgmt_byte_enable;
	logic                    mgmt_read;
	logic [`MGMT_DATA_W-1:0] mgmt_read_data;
	logic                    mgmt_done;
	logic                    type1_readonly_override;
	logic                    link_down;

	modport device (
		input  mgmt_addr,
		input  mgmt_write,
		input  mgmt_write_data,
		input  mgmt_byte_enable,
		input  mgmt_read,
		input  type1_readonly_override,
		output mgmt_read_data,
		output mgmt_done,
		output link_down
	);

	modport host (
		output mgmt_addr,
		output mgmt_write,
		output mgmt_write_data,
		output mgmt_byte_enable,
		output mgmt_read,
		output type1_readonly_override,
		input  mgmt_read_data,
		input  mgmt_done,
		input  link_down
	);
endinterface // cfg_mgmt_if

/* File: rtl/cfg_space_mgmt.sv */
/*
 * Configuration space end of the management port: a small register
 * space per function, byte-enabled writes, registered reads, a one-cycle
 * completion pulse, and the link-down status output.
 * Assumes the requester holds its request until completion and keeps one
 * access outstanding; link_up_state_in comes from another domain.
 */
`timescale 1ns/1ps
`include "cfg_mgmt_consts.svh"

module cfg_space_mgmt (
	input  wire logic    clk_sys_in,
	input  wire logic    sys_rst_in,
	cfg_mgmt_if.device   mgmt,
	input  wire logic    root_port_mode_in,
	input  wire logic    link_up_state_in,
	output logic         link_down_out
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------

	// bits that software may not change without the override
	function automatic logic [`MGMT_DATA_W-1:0] ro_mask(input logic [`MGMT_REG_W-1:0] reg_sel);
		logic [`MGMT_DATA_W-1:0] m;
		m = `MGMT_MASK_NONE;
		if (reg_sel == `MGMT_REG_IDENT || reg_sel == `MGMT_REG_CLASS) begin
			m = `MGMT_MASK_ALL_RO;
		end else if (reg_sel == `MGMT_REG_BUSNUM) begin
			m = `MGMT_MASK_BUS_RO;
		end
		return m;
	endfunction

	function automatic logic [`MGMT_DATA_W-1:0] rst_value(input logic [`MGMT_REG_W-1:0] reg_sel);
		logic [`MGMT_DATA_W-1:0] v;
		v = `MGMT_RST_ZERO;
		if (reg_sel == `MGMT_REG_IDENT) begin
			v = `MGMT_RST_IDENT;
		end else if (reg_sel == `MGMT_REG_CLASS) begin
			v = `MGMT_RST_CLASS;
		end
		return v;
	endfunction

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic [`MGMT_FUNC_W-1:0] func_sel;
	logic [`MGMT_REG_W-1:0]  reg_sel;
	logic                    space_mgmt;
	logic                    hit;
	logic                    func_idx;
	logic [`MGMT_IDX_W-1:0]  reg_idx;
	logic                    is_type1_reg;

	assign space_mgmt   = mgmt.mgmt_addr[`MGMT_SPACE_BIT];
	assign func_sel     = mgmt.mgmt_addr[`MGMT_FUNC_HI:`MGMT_FUNC_LO];
	assign reg_sel      = mgmt.mgmt_addr[`MGMT_REG_HI:`MGMT_REG_LO];
	// only the low functions and registers exist; the rest read zero
	assign hit          = !space_mgmt
	                    && (func_sel < `MGMT_FUNC_W'(`MGMT_NUM_FUNC))
	                    && (reg_sel < `MGMT_REG_W'(`MGMT_NUM_REGS));
	assign func_idx     = func_sel[0];
	assign reg_idx      = reg_sel[`MGMT_IDX_W-1:0];
	assign is_type1_reg = hit && (reg_sel < `MGMT_HDR_REGS);

	// ------------------------------------------------------------
	// access sequencing
	// ------------------------------------------------------------
	cfg_mgmt_pkg::dev_state_e state_q;
	cfg_mgmt_pkg::dev_state_e state_d;
	logic                     take;
	logic                     strobe;

	assign strobe = mgmt.mgmt_read || mgmt.mgmt_write;
	// a held strobe is taken once; HOLD waits for it to fall
	assign take   = (state_q == cfg_mgmt_pkg::DEV_IDLE) && strobe;

	always_comb begin
		state_d = state_q;
		case (state_q)
			cfg_mgmt_pkg::DEV_IDLE: begin
				if (take) begin
					state_d = cfg_mgmt_pkg::DEV_HOLD;
				end
			end
			cfg_mgmt_pkg::DEV_HOLD: begin
				if (!strobe) begin
					state_d = cfg_mgmt_pkg::DEV_IDLE;
				end
			end
			default: begin
				state_d = cfg_mgmt_pkg::DEV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state_q <= cfg_mgmt_pkg::DEV_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// register space and write merge
	// ------------------------------------------------------------
	logic [`MGMT_DATA_W-1:0] space_q [`MGMT_NUM_FUNC][`MGMT_NUM_REGS];
	logic [`MGMT_DATA_W-1:0] cur_word;
	logic [`MGMT_DATA_W-1:0] lane_mask;
	logic [`MGMT_DATA_W-1:0] wr_mask;
	logic [`MGMT_DATA_W-1:0] new_word;
	logic                    override;
	logic                    do_write;

	assign cur_word = hit ? space_q[func_idx][reg_idx] : `MGMT_RST_ZERO;

	genvar lane;
	generate
		for (lane = 0; lane < `MGMT_BE_W; lane++) begin : g_lane
			assign lane_mask[lane*`MGMT_BYTE_W +: `MGMT_BYTE_W] =
				{`MGMT_BYTE_W{mgmt.mgmt_byte_enable[lane]}};
		end
	endgenerate

	// the override only opens header fields, and only in root port mode
	assign override = root_port_mode_in && is_type1_reg && mgmt.type1_readonly_override;
	assign wr_mask  = override ? lane_mask : (lane_mask & ~ro_mask(reg_sel));
	assign new_word = (cur_word & ~wr_mask) | (mgmt.mgmt_write_data & wr_mask);
	// a write wins if both strobes appear; the requester must not do this
	assign do_write = take && mgmt.mgmt_write && hit;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			for (int f = 0; f < `MGMT_NUM_FUNC; f++) begin
				for (int r = 0; r < `MGMT_NUM_REGS; r++) begin
					space_q[f][r] <= rst_value(`MGMT_REG_W'(r));
				end
			end
		end else if (do_write) begin
			space_q[func_idx][reg_idx] <= new_word;
		end
	end

	// ------------------------------------------------------------
	// read data and completion
	// ------------------------------------------------------------
	logic [`MGMT_DATA_W-1:0] read_data_q;
	logic                    done_q;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			read_data_q <= `MGMT_RST_ZERO;
			done_q      <= 1'b0;
		end else begin
			done_q <= take;
			if (take && mgmt.mgmt_read && !mgmt.mgmt_write) begin
				read_data_q <= cur_word;
			end
		end
	end

	assign mgmt.mgmt_read_data = read_data_q;
	assign mgmt.mgmt_done      = done_q;

	// ------------------------------------------------------------
	// link-down status
	// ------------------------------------------------------------
	// link-up comes from the phy domain, so it is synchronised first
	logic link_up_meta_q;
	logic link_up_sync_q;
	logic link_down_q;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			link_up_meta_q <= 1'b0;
			link_up_sync_q <= 1'b0;
			link_down_q    <= 1'b0;
		end else begin
			link_up_meta_q <= link_up_state_in;
			link_up_sync_q <= link_up_meta_q;
			link_down_q    <= !link_up_sync_q;
		end
	end

	assign mgmt.link_down = link_down_q;
	assign link_down_out  = link_down_q;

endmodule // cfg_space_mgmt

/* File: rtl/cfg_mgmt_requester.sv */
/*
 * Configuration manager end: takes one user request, drives the
 * management strobes until completion, returns read data.
 * Assumes the configuration space end shares clock and reset.
 */
`timescale 1ns/1ps
`include "cfg_mgmt_consts.svh"

module cfg_mgmt_requester (
	input  wire logic                    clk_sys_in,
	input  wire logic                    sys_rst_in,
	cfg_mgmt_if.host                     mgmt,
	input  wire logic                    req_read_in,
	input  wire logic                    req_write_in,
	input  wire logic [`MGMT_ADDR_W-1:0] req_addr_in,
	input  wire logic [`MGMT_DATA_W-1:0] req_wdata_in,
	input  wire logic [`MGMT_BE_W-1:0]   req_be_in,
	input  wire logic                    req_override_in,
	output logic                         busy_out,
	output logic                         done_out,
	output logic [`MGMT_DATA_W-1:0]      rdata_out,
	output logic                         link_down_out
);

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	cfg_mgmt_pkg::req_state_e state_q;
	cfg_mgmt_pkg::req_state_e state_d;
	logic                     accept;

	// write has priority so both strobes never rise together
	assign accept = (state_q == cfg_mgmt_pkg::REQ_IDLE) && (req_read_in || req_write_in);

	always_comb begin
		state_d = state_q;
		case (state_q)
			cfg_mgmt_pkg::REQ_IDLE: begin
				if (accept) begin
					state_d = cfg_mgmt_pkg::REQ_WAIT;
				end
			end
			cfg_mgmt_pkg::REQ_WAIT: begin
				if (mgmt.mgmt_done) begin
					state_d = cfg_mgmt_pkg::REQ_DROP;
				end
			end
			// one idle cycle lets the far end see the strobe fall
			cfg_mgmt_pkg::REQ_DROP: begin
				state_d = cfg_mgmt_pkg::REQ_IDLE;
			end
			default: begin
				state_d = cfg_mgmt_pkg::REQ_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// request registers
	// ------------------------------------------------------------
	logic [`MGMT_ADDR_W-1:0] addr_q;
	logic [`MGMT_DATA_W-1:0] wdata_q;
	logic [`MGMT_BE_W-1:0]   be_q;
	logic                    write_q;
	logic                    read_q;
	logic                    override_q;
	logic                    done_q;
	logic [`MGMT_DATA_W-1:0] rdata_q;
	logic                    finish;

	assign finish = (state_q == cfg_mgmt_pkg::REQ_WAIT) && mgmt.mgmt_done;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state_q    <= cfg_mgmt_pkg::REQ_IDLE;
			addr_q     <= `MGMT_ADDR_W'(0);
			wdata_q    <= `MGMT_RST_ZERO;
			be_q       <= `MGMT_BE_W'(0);
			write_q    <= 1'b0;
			read_q     <= 1'b0;
			override_q <= 1'b0;
			done_q     <= 1'b0;
			rdata_q    <= `MGMT_RST_ZERO;
		end else begin
			state_q <= state_d;
			done_q  <= finish;
			if (accept) begin
				// held steady until completion
				addr_q     <= req_addr_in;
				wdata_q    <= req_wdata_in;
				be_q       <= req_be_in;
				override_q <= req_override_in;
				write_q    <= req_write_in;
				read_q     <= req_read_in && !req_write_in;
			end else if (finish) begin
				write_q <= 1'b0;
				read_q  <= 1'b0;
			end
			if (finish && read_q) begin
				rdata_q <= mgmt.mgmt_read_data;
			end
		end
	end

	assign mgmt.mgmt_addr               = addr_q;
	assign mgmt.mgmt_write_data         = wdata_q;
	assign mgmt.mgmt_byte_enable        = be_q;
	assign mgmt.mgmt_write              = write_q;
	assign mgmt.mgmt_read               = read_q;
	assign mgmt.type1_readonly_override = override_q;

	// ------------------------------------------------------------
	// user side status
	// ------------------------------------------------------------
	logic busy_q;
	logic link_down_q;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			busy_q      <= 1'b0;
			link_down_q <= 1'b0;
		end else begin
			busy_q      <= (state_d != cfg_mgmt_pkg::REQ_IDLE);
			link_down_q <= mgmt.link_down;
		end
	end

	assign busy_out      = busy_q;
	assign done_out      = done_q;
	assign rdata_out     = rdata_q;
	assign link_down_out = link_down_q;

endmodule // cfg_mgmt_requester

/* File: bench/cfg_mgmt_asserts.sv */
/*
 * Checker for the management port wires between requester and space.
 * Assumes one clock domain and the interface signals as plain inputs.
 */
`timescale 1ns/1ps
`include "cfg_mgmt_consts.svh"

module cfg_mgmt_asserts (
	input wire logic                    clk_sys_in,
	input wire logic                    sys_rst_in,
	input wire logic [`MGMT_ADDR_W-1:0] mgmt_addr,
	input wire logic                    mgmt_write,
	input wire logic [`MGMT_DATA_W-1:0] mgmt_write_data,
	input wire logic [`MGMT_BE_W-1:0]   mgmt_byte_enable,
	input wire logic                    mgmt_read,
	input wire logic [`MGMT_DATA_W-1:0] mgmt_read_data,
	input wire logic                    mgmt_done,
	input wire logic                    type1_readonly_override,
	input wire logic                    link_down
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	wire logic strobe;
	wire logic plain_read;
	assign strobe = mgmt_read | mgmt_write;
	assign plain_read = mgmt_done & mgmt_read & ~mgmt_write;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_done_single_cycle: assert property (mgmt_done |=> !mgmt_done)
		else $error("completion longer than one cycle");
	a_done_after_take: assert property ($rose(strobe) |=> mgmt_done)
		else $error("no completion after access taken");
	a_done_has_cause: assert property (mgmt_done |-> strobe && $past(strobe))
		else $error("completion without access");
	a_strobe_shape: assert property ($rose(strobe) |-> strobe [*2] ##1 !strobe)
		else $error("strobe not held to completion");
	a_request_stable: assert property (strobe && !mgmt_done |=>
		$stable(mgmt_addr) && $stable(mgmt_write_data) && $stable(mgmt_byte_enable))
		else $error("request changed before completion");
	a_single_strobe: assert property (!(mgmt_read && mgmt_write))
		else $error("read and write strobes together");
	a_space_bit_zero: assert property (plain_read && mgmt_addr[`MGMT_SPACE_BIT] |-> mgmt_read_data == '0)
		else $error("unimplemented space read not zero");
	a_func_range: assert property (plain_read && mgmt_addr[`MGMT_FUNC_HI:`MGMT_FUNC_LO] >= `MGMT_NUM_FUNC
		|-> mgmt_read_data == '0)
		else $error("absent function read not zero");
	a_rdata_hold: assert property (!mgmt_done |-> $stable(mgmt_read_data))
		else $error("read data moved without completion");
	a_link_rst_low: assert property ($fell(sys_rst_in) |-> !link_down)
		else $error("link down high at reset release");

	c_write: cover property ($rose(mgmt_write));
	c_read_done: cover property (plain_read);
	c_override: cover property (mgmt_write && type1_readonly_override);
	c_link_down: cover property ($rose(link_down));
endmodule // cfg_mgmt_asserts

/* File: bench/config_space_mgmt_port_tb.sv */
/*
 * Bench: requester and configuration space joined by the interface,
 * checked against a model of the register space.
 * Assumes rtl/ is on the include path.
 */
`timescale 1ns/1ps
`include "cfg_mgmt_consts.svh"

module config_space_mgmt_port_tb;
	logic                    clk_sys_in;
	logic                    sys_rst_in;
	logic                    root_port_mode_in;
	logic                    link_up_state_in;
	logic                    req_read;
	logic                    req_write;
	logic [`MGMT_ADDR_W-1:0] req_addr;
	logic [`MGMT_DATA_W-1:0] req_wdata;
	logic [`MGMT_BE_W-1:0]   req_be;
	logic                    req_override;
	logic                    busy;
	logic                    done;
	logic [`MGMT_DATA_W-1:0] rdata;
	logic                    dev_link_down;
	logic                    req_link_down;
	logic [`MGMT_DATA_W-1:0] mem [`MGMT_NUM_FUNC][`MGMT_NUM_REGS];
	logic [9:0]              hdr [3] = '{`MGMT_REG_IDENT, `MGMT_REG_CLASS, `MGMT_REG_BUSNUM};
	logic [`MGMT_ADDR_W-1:0] a;
	int                      n_errors;
	int                      n_tests;
	int                      seed;
	int                      i;

	cfg_mgmt_if cfg_mgmt_if_inst ();

	cfg_space_mgmt cfg_space_mgmt_inst (
		.clk_sys_in        (clk_sys_in),
		.sys_rst_in        (sys_rst_in),
		.mgmt              (cfg_mgmt_if_inst),
		.root_port_mode_in (root_port_mode_in),
		.link_up_state_in  (link_up_state_in),
		.link_down_out     (dev_link_down)
	);

	cfg_mgmt_requester cfg_mgmt_requester_inst (
		.clk_sys_in      (clk_sys_in),
		.sys_rst_in      (sys_rst_in),
		.mgmt            (cfg_mgmt_if_inst),
		.req_read_in     (req_read),
		.req_write_in    (req_write),
		.req_addr_in     (req_addr),
		.req_wdata_in    (req_wdata),
		.req_be_in       (req_be),
		.req_override_in (req_override),
		.busy_out        (busy),
		.done_out        (done),
		.rdata_out       (rdata),
		.link_down_out   (req_link_down)
	);

	cfg_mgmt_asserts cfg_mgmt_asserts_inst (
		.clk_sys_in              (clk_sys_in),
		.sys_rst_in              (sys_rst_in),
		.mgmt_addr               (cfg_mgmt_if_inst.mgmt_addr),
		.mgmt_write              (cfg_mgmt_if_inst.mgmt_write),
		.mgmt_write_data         (cfg_mgmt_if_inst.mgmt_write_data),
		.mgmt_byte_enable        (cfg_mgmt_if_inst.mgmt_byte_enable),
		.mgmt_read               (cfg_mgmt_if_inst.mgmt_read),
		.mgmt_read_data          (cfg_mgmt_if_inst.mgmt_read_data),
		.mgmt_done               (cfg_mgmt_if_inst.mgmt_done),
		.type1_readonly_override (cfg_mgmt_if_inst.type1_readonly_override),
		.link_down               (cfg_mgmt_if_inst.link_down)
	);

	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	function automatic logic [31:0] ro_mask(input logic [9:0] r);
		case (r)
			`MGMT_REG_IDENT, `MGMT_REG_CLASS: return `MGMT_MASK_ALL_RO;
			`MGMT_REG_BUSNUM:                 return `MGMT_MASK_BUS_RO;
			default:                          return `MGMT_MASK_NONE;
		endcase
	endfunction

	function automatic logic hit(input logic [18:0] x);
		return !x[18] && x[17:10] < `MGMT_NUM_FUNC && x[9:0] < `MGMT_NUM_REGS;
	endfunction

	// holds the synchronous reset and restores the model's reset image
	task automatic do_reset();
		sys_rst_in = 1'b1;
		tick(12);
		check(dev_link_down, 0);
		for (int f = 0; f < `MGMT_NUM_FUNC; f++) begin
			for (int r = 0; r < `MGMT_NUM_REGS; r++) begin
				mem[f][r] = (r == 0) ? `MGMT_RST_IDENT : (r == 2) ? `MGMT_RST_CLASS : `MGMT_RST_ZERO;
			end
		end
		sys_rst_in = 1'b0;
	endtask

	// one access through the requester; requests are dropped once taken
	task automatic access(input logic w, input logic [18:0] x, input logic [31:0] d, input logic [3:0] b,
		input logic o);
		logic [31:0] m;
		logic [31:0] bm;
		int          k;
		req_write = w;
		req_read = !w;
		req_addr = x;
		req_wdata = d;
		req_be = b;
		req_override = o;
		tick(1);
		check(busy, 1);
		req_write = 1'b0;
		req_read = 1'b0;
		for (k = 0; k < 20 && done !== 1'b1; k++) tick(1);
		check(k < 20, 1);
		if (k >= 20) close_out();
		bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		m = (root_port_mode_in && o && x[9:0] < `MGMT_HDR_REGS) ? '0 : ro_mask(x[9:0]);
		if (w && hit(x)) begin
			mem[x[10]][x[5:0]] = (mem[x[10]][x[5:0]] & (m | ~bm)) | (d & ~m & bm);
		end else if (!w) begin
			check(rdata, hit(x) ? mem[x[10]][x[5:0]] : '0);
		end
		for (k = 0; k < 20 && busy !== 1'b0; k++) tick(1);
		check(k < 20, 1);
		if (k >= 20) close_out();
		if (n_errors > 40) close_out();
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		n_errors = 0;
		n_tests = 0;
		seed = 32'h068E;
		root_port_mode_in = 1'b0;
		link_up_state_in = 1'b0;
		req_read = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		req_be = '0;
		req_override = 1'b0;
		do_reset();
		tick(5);
		check(dev_link_down, 1);
		check(req_link_down, 1);
		link_up_state_in = 1'b1;
		tick(5);
		check(dev_link_down, 0);
		check(req_link_down, 0);
		for (i = 0; i < 6; i++) access(0, {1'b0, 8'(i / 3), hdr[i % 3]}, '0, '0, 0);
		// every mode and override pairing on fully and partly read-only header words
		for (i = 0; i < 8; i++) begin
			root_port_mode_in = i[2];
			a = {1'b0, 8'h00, i[0] ? `MGMT_REG_IDENT : `MGMT_REG_BUSNUM};
			access(1, a, $random(seed), 4'hF, i[1]);
			access(0, a, '0, '0, 0);
		end
		access(1, 19'h00408, 32'hFFFFFFFF, 4'h0, 0);
		access(0, 19'h00408, '0, '0, 0);
		for (i = 0; i < 60; i++) begin
			a = {{$random(seed)} % 8 == 0, 8'({$random(seed)} % 3), 10'({$random(seed)} % 72)};
			root_port_mode_in = 1'($random(seed));
			access(1, a, $random(seed), 4'($random(seed)), 1'($random(seed)));
			access(0, a, '0, '0, 0);
		end
		// link lost across this reset, so the held-low output means something
		link_up_state_in = 1'b0;
		do_reset();
		access(0, {1'b0, 8'h01, `MGMT_REG_IDENT}, '0, '0, 0);
		check(dev_link_down, 1);
		close_out();
	end
endmodule // config_space_mgmt_port_tb
